// *** trig_seq.v ***
// Trigger sequencer with arm/trigger layers, Avalon-MM registers and level trigger
`timescale 1ns/1ps
`include "trig_seq_defs.vh"

// Notes on behaviour
// - Local quick setup: trigger immediate, count one
// - Continuous initiation keeps looping, idles only for one cycle after abort
// - Otherwise idle after arm*trigger*sample measurements
// - Manual key starts sequence from idle
// - External arm makes line 1 trigger input
// - Arm source imm/ext/man/bus; bus remote only
// - Sample count limited to 2500
// - Trigger source imm/ext/man only
// - Arm count repeats arm layer passes
// - Trigger count repeats per arm pass
// - Sample count measurements per trigger event
// - Force bypasses waiting layer's event
// - Initiate leaves idle, enters arm layer
// - Abort returns sequence to idle; continuous re-enters arm next cycle
// - Configuration retained across remote to local
// - Level crossing in direction starts logging
// - Voltage level trigger own enable/level/direction
// - Current level trigger independent settings
// - Activation discards all but pretrigger entries
// - Shared pretrigger offset for both triggers
// - Bus trigger command fires bus arm
// - Source, settle delay, then measure
// - Optional output pulse after measurement
module trig_seq #(
   parameter W = 16,
   parameter DELAY_UNIT = `DELAY_UNIT_CYC,
   parameter MC_LEN = `MC_PULSE_CYC
) (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // Avalon-MM slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Front panel and digital line 1
   input wire trig_key_i,
   input wire ext_trig_i,
   output wire line1_trig_in_o,
   // Measurement path
   input wire meas_done_i,
   input wire [W-1:0] v_meas_i,
   input wire [W-1:0] i_meas_i,
   output wire source_o,
   output wire measure_o,
   output reg meter_done_o,
   // Data log control
   output wire log_en_o,
   output wire log_clear_o,
   output wire [15:0] log_keep_o
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ARM = 3'h1;
   localparam ST_TRIG = 3'h2;
   localparam ST_SRC = 3'h3;
   localparam ST_DLY = 3'h4;
   localparam ST_MEAS = 3'h5;

   // ==========================================
   // Input synchronisers
   reg [1:0] key_s_r;
   reg [1:0] ext_s_r;
   reg key_d_r;
   reg ext_d_r;
   wire key_ev;
   wire ext_ev;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         key_s_r <= 2'h0;
         ext_s_r <= 2'h0;
         key_d_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         key_s_r <= {key_s_r[0], trig_key_i};
         ext_s_r <= {ext_s_r[0], ext_trig_i};
         key_d_r <= key_s_r[1];
         ext_d_r <= ext_s_r[1];
      end
   end

   assign key_ev = key_s_r[1] & ~key_d_r;
   assign ext_ev = ext_s_r[1] & ~ext_d_r;

   // ==========================================
   // Configuration registers
   reg cont_r;
   reg [1:0] arm_src_r;
   reg [1:0] trig_src_r;
   reg remote_r;
   reg quick_r;
   reg mc_en_r;
   reg [15:0] arm_cnt_r;
   reg [15:0] trig_cnt_r;
   reg [11:0] samp_cnt_r;
   reg [19:0] delay_r;
   reg [W-1:0] vlvl_r;
   reg [W-1:0] ilvl_r;
   reg v_en_r;
   reg v_rise_r;
   reg i_en_r;
   reg i_rise_r;
   reg [15:0] ofs_r;

   wire wr = avs_write;
   wire [1:0] wr_arm_src = avs_writedata[`CTRL_ARM_SRC_LO+1:`CTRL_ARM_SRC_LO];
   wire [1:0] wr_trig_src = avs_writedata[`CTRL_TRIG_SRC_LO+1:`CTRL_TRIG_SRC_LO];
   wire wr_remote = avs_writedata[`CTRL_REMOTE];
   wire [11:0] wr_samp = avs_writedata[11:0];
   wire cmd_wr = wr & (avs_address == `REG_CMD);
   wire cmd_init = cmd_wr & avs_writedata[`CMD_INIT];
   wire cmd_abort = cmd_wr & avs_writedata[`CMD_ABORT];
   wire cmd_force = cmd_wr & avs_writedata[`CMD_FORCE];
   wire cmd_bus = cmd_wr & avs_writedata[`CMD_BUS_TRG];

   // One wait state on reads, so read data stands when the master takes it
   reg rd_vld_r;
   assign avs_waitrequest = avs_read & ~rd_vld_r;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cont_r <= 1'b0;
         arm_src_r <= `SRC_IMM;
         trig_src_r <= `SRC_IMM;
         remote_r <= 1'b0;
         quick_r <= 1'b0;
         mc_en_r <= 1'b0;
         arm_cnt_r <= `ARM_CNT_RST;
         trig_cnt_r <= `TRIG_CNT_RST;
         samp_cnt_r <= `SAMP_CNT_RST;
         delay_r <= 20'h00000;
         vlvl_r <= {W{1'b0}};
         ilvl_r <= {W{1'b0}};
         v_en_r <= 1'b0;
         v_rise_r <= 1'b0;
         i_en_r <= 1'b0;
         i_rise_r <= 1'b0;
         ofs_r <= 16'h0000;
      end else if (wr) begin
         // Nothing resets on a remote-to-local change; settings persist
         case (avs_address)
            `REG_CTRL: begin
               cont_r <= avs_writedata[`CTRL_CONT];
               remote_r <= wr_remote;
               quick_r <= avs_writedata[`CTRL_QUICK];
               mc_en_r <= avs_writedata[`CTRL_MC_EN];
               // Bus arm source refused unless written in remote mode
               if (wr_arm_src != `SRC_BUS || wr_remote) begin
                  arm_src_r <= wr_arm_src;
               end
               // Bus is not a trigger-layer source
               if (wr_trig_src != `SRC_BUS) begin
                  trig_src_r <= wr_trig_src;
               end
            end
            `REG_ARM_CNT: begin
               if (avs_writedata[15:0] != 16'h0000) begin
                  arm_cnt_r <= avs_writedata[15:0];
               end
            end
            `REG_TRIG_CNT: begin
               if (avs_writedata[15:0] != 16'h0000) begin
                  trig_cnt_r <= avs_writedata[15:0];
               end
            end
            `REG_SAMP_CNT: begin
               if (avs_writedata[31:12] == 20'h00000 && wr_samp != 12'h000 && wr_samp <= `SAMP_CNT_MAX) begin
                  samp_cnt_r <= wr_samp;
               end
            end
            `REG_DELAY: begin
               if (avs_writedata[31:20] == 12'h000 && avs_writedata[19:0] <= `DELAY_MAX) begin
                  delay_r <= avs_writedata[19:0];
               end
            end
            `REG_VLVL: vlvl_r <= avs_writedata[W-1:0];
            `REG_ILVL: ilvl_r <= avs_writedata[W-1:0];
            `REG_LVL_CFG: begin
               v_en_r <= avs_writedata[`LVL_V_EN];
               v_rise_r <= avs_writedata[`LVL_V_RISE];
               i_en_r <= avs_writedata[`LVL_I_EN];
               i_rise_r <= avs_writedata[`LVL_I_RISE];
               ofs_r <= avs_writedata[`LVL_OFS_LO+15:`LVL_OFS_LO];
            end
            default: begin
            end
         endcase
      end
   end

   // Local quick setup overrides trigger layer source and count
   wire quick_local = quick_r & ~remote_r;
   wire [1:0] eff_trig_src = quick_local ? `SRC_IMM : trig_src_r;
   wire [15:0] eff_trig_cnt = quick_local ? 16'h0001 : trig_cnt_r;

   // ==========================================
   // Sequencer
   reg [2:0] st_r;
   reg [15:0] arm_i_r;
   reg [15:0] trig_i_r;
   reg [11:0] samp_i_r;
   reg [19:0] dly_i_r;
   reg [13:0] unit_i_r;
   reg [3:0] mc_i_r;
   reg logging_r;
   reg clr_r;
   reg bus_pend_r;
   reg [31:0] meas_tot_r;
   wire lvl_fire;

   function ev_hit;
      input [1:0] src;
      input ke;
      input xe;
      input be;
      begin
         case (src)
            `SRC_IMM: ev_hit = 1'b1;
            `SRC_EXT: ev_hit = xe;
            `SRC_MAN: ev_hit = ke;
            default: ev_hit = be;
         endcase
      end
   endfunction

   wire arm_go = cmd_force | ev_hit(arm_src_r, key_ev, ext_ev, bus_pend_r | cmd_bus);
   wire trig_go = cmd_force | ev_hit(eff_trig_src, key_ev, ext_ev, 1'b0);
   wire last_samp = (samp_i_r == samp_cnt_r - 12'h001);
   wire last_trig = (trig_i_r == eff_trig_cnt - 16'h0001);
   wire last_arm = (arm_i_r == arm_cnt_r - 16'h0001);

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= ST_IDLE;
         arm_i_r <= 16'h0000;
         trig_i_r <= 16'h0000;
         samp_i_r <= 12'h000;
         dly_i_r <= 20'h00000;
         unit_i_r <= 14'h0000;
         bus_pend_r <= 1'b0;
         meas_tot_r <= 32'h00000000;
      end else if (cmd_abort) begin
         st_r <= ST_IDLE;
         arm_i_r <= 16'h0000;
         trig_i_r <= 16'h0000;
         samp_i_r <= 12'h000;
         dly_i_r <= 20'h00000;
         unit_i_r <= 14'h0000;
         bus_pend_r <= 1'b0;
      end else begin
         // Bus trigger latched while arm waits
         if (cmd_bus && st_r == ST_ARM) begin
            bus_pend_r <= 1'b1;
         end
         case (st_r)
            ST_IDLE: begin
               if (cmd_init || key_ev || cont_r) begin
                  st_r <= ST_ARM;
               end
            end
            ST_ARM: begin
               if (arm_go) begin
                  bus_pend_r <= 1'b0;
                  st_r <= ST_TRIG;
               end
            end
            ST_TRIG: begin
               if (trig_go) begin
                  st_r <= ST_SRC;
               end
            end
            ST_SRC: begin
               dly_i_r <= 20'h00000;
               unit_i_r <= 14'h0000;
               st_r <= ST_DLY;
            end
            ST_DLY: begin
               if (dly_i_r == delay_r) begin
                  st_r <= ST_MEAS;
               end else if (unit_i_r == DELAY_UNIT - 1) begin
                  unit_i_r <= 14'h0000;
                  dly_i_r <= dly_i_r + 20'h00001;
               end else begin
                  unit_i_r <= unit_i_r + 14'h0001;
               end
            end
            ST_MEAS: begin
               if (meas_done_i) begin
                  meas_tot_r <= meas_tot_r + 32'h00000001;
                  if (!last_samp) begin
                     samp_i_r <= samp_i_r + 12'h001;
                     st_r <= ST_DLY;
                     dly_i_r <= delay_r;
                  end else begin
                     samp_i_r <= 12'h000;
                     if (!last_trig) begin
                        trig_i_r <= trig_i_r + 16'h0001;
                        st_r <= ST_TRIG;
                     end else begin
                        trig_i_r <= 16'h0000;
                        if (!last_arm) begin
                           arm_i_r <= arm_i_r + 16'h0001;
                           st_r <= ST_ARM;
                        end else begin
                           arm_i_r <= 16'h0000;
                           st_r <= cont_r ? ST_ARM : ST_IDLE;
                        end
                     end
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   assign source_o = (st_r == ST_SRC);
   assign measure_o = (st_r == ST_MEAS);
   assign line1_trig_in_o = (arm_src_r == `SRC_EXT) | (trig_src_r == `SRC_EXT);

   // ==========================================
   // Meter complete pulse and level-triggered logging
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mc_i_r <= 4'h0;
         meter_done_o <= 1'b0;
         logging_r <= 1'b0;
         clr_r <= 1'b0;
      end else begin
         if (st_r == ST_MEAS && meas_done_i && mc_en_r) begin
            mc_i_r <= MC_LEN[3:0];
            meter_done_o <= 1'b1;
         end else if (mc_i_r > 4'h1) begin
            mc_i_r <= mc_i_r - 4'h1;
         end else begin
            mc_i_r <= 4'h0;
            meter_done_o <= 1'b0;
         end
         clr_r <= lvl_fire & ~logging_r;
         if (lvl_fire) begin
            logging_r <= 1'b1;
         end else if (wr && avs_address == `REG_LVL_CFG) begin
            logging_r <= 1'b0;
         end
      end
   end

   level_trig #(
      .W(W)
   ) u_level (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .v_en_i(v_en_r),
      .v_rise_i(v_rise_r),
      .v_lvl_i(vlvl_r),
      .i_en_i(i_en_r),
      .i_rise_i(i_rise_r),
      .i_lvl_i(ilvl_r),
      .samp_vld_i(meas_done_i),
      .v_meas_i(v_meas_i),
      .i_meas_i(i_meas_i),
      .fire_o(lvl_fire)
   );

   assign log_en_o = logging_r;
   assign log_clear_o = clr_r;
   assign log_keep_o = ofs_r;

   // ==========================================
   // Read mux, registered data
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata <= 32'h00000000;
         rd_vld_r <= 1'b0;
      end else if (avs_read && !rd_vld_r) begin
         rd_vld_r <= 1'b1;
         case (avs_address)
            `REG_CTRL: avs_readdata <= {24'h000000, mc_en_r, quick_r, remote_r, trig_src_r, arm_src_r, cont_r};
            `REG_ARM_CNT: avs_readdata <= {16'h0000, arm_cnt_r};
            `REG_TRIG_CNT: avs_readdata <= {16'h0000, trig_cnt_r};
            `REG_SAMP_CNT: avs_readdata <= {20'h00000, samp_cnt_r};
            `REG_DELAY: avs_readdata <= {12'h000, delay_r};
            `REG_VLVL: avs_readdata <= {{(32-W){1'b0}}, vlvl_r};
            `REG_ILVL: avs_readdata <= {{(32-W){1'b0}}, ilvl_r};
            `REG_LVL_CFG: avs_readdata <= {ofs_r, 12'h000, i_rise_r, i_en_r, v_rise_r, v_en_r};
            `REG_STATUS: avs_readdata <= {27'h0000000, logging_r, line1_trig_in_o, st_r};
            `REG_MEAS_DONE: avs_readdata <= meas_tot_r;
            default: avs_readdata <= 32'h00000000;
         endcase
      end else begin
         rd_vld_r <= 1'b0;
      end
   end

endmodule

// *** trig_seq_defs.vh ***
// Register offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef TRIG_SEQ_DEFS_VH
`define TRIG_SEQ_DEFS_VH

// ==========================================
// Register word offsets (byte address = 4 * index)
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_ARM_CNT 4'h2
`define REG_TRIG_CNT 4'h3
`define REG_SAMP_CNT 4'h4
`define REG_DELAY 4'h5
`define REG_VLVL 4'h6
`define REG_ILVL 4'h7
`define REG_LVL_CFG 4'h8
`define REG_STATUS 4'h9
`define REG_MEAS_DONE 4'hA

// ==========================================
// CTRL fields
`define CTRL_CONT 0
`define CTRL_ARM_SRC_LO 1
`define CTRL_TRIG_SRC_LO 3
`define CTRL_REMOTE 5
`define CTRL_QUICK 6
`define CTRL_MC_EN 7

// ==========================================
// CMD bits (write-one pulses)
`define CMD_INIT 0
`define CMD_ABORT 1
`define CMD_FORCE 2
`define CMD_BUS_TRG 3

// ==========================================
// LVL_CFG fields
`define LVL_V_EN 0
`define LVL_V_RISE 1
`define LVL_I_EN 2
`define LVL_I_RISE 3
`define LVL_OFS_LO 16

// ==========================================
// Event sources
`define SRC_IMM 2'h0
`define SRC_EXT 2'h1
`define SRC_MAN 2'h2
`define SRC_BUS 2'h3

// ==========================================
// Reset values and sample count limit
`define ARM_CNT_RST 16'h0001
`define TRIG_CNT_RST 16'h0001
`define SAMP_CNT_RST 12'h001
`define SAMP_CNT_MAX 12'h9C4

// ==========================================
// Timing: delay register counts units of 100 us, max 999999 units
`define DELAY_UNIT_NS 100000
`define CLK_PERIOD_NS 100
`define DELAY_UNIT_CYC (`DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define DELAY_MAX 20'hF423F
`define MC_PULSE_CYC 4'hA

`endif

// *** level_trig.v ***
// Level trigger: threshold crossing on voltage or current
`timescale 1ns/1ps
module level_trig #(
   parameter W = 16
) (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // Configuration
   input wire v_en_i,
   input wire v_rise_i,
   input wire [W-1:0] v_lvl_i,
   input wire i_en_i,
   input wire i_rise_i,
   input wire [W-1:0] i_lvl_i,
   // Samples
   input wire samp_vld_i,
   input wire [W-1:0] v_meas_i,
   input wire [W-1:0] i_meas_i,
   // Result
   output wire fire_o
);

   reg v_above_r;
   reg i_above_r;
   reg prim_r;
   wire v_above_nxt;
   wire i_above_nxt;
   wire v_hit;
   wire i_hit;

   assign v_above_nxt = (v_meas_i > v_lvl_i);
   assign i_above_nxt = (i_meas_i > i_lvl_i);
   // Crossing only: the first sample after reset primes history
   assign v_hit = v_en_i & prim_r & (v_rise_i ? (v_above_nxt & ~v_above_r) : (~v_above_nxt & v_above_r));
   assign i_hit = i_en_i & prim_r & (i_rise_i ? (i_above_nxt & ~i_above_r) : (~i_above_nxt & i_above_r));
   assign fire_o = samp_vld_i & (v_hit | i_hit);

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         v_above_r <= 1'b0;
         i_above_r <= 1'b0;
         prim_r <= 1'b0;
      end else if (samp_vld_i) begin
         v_above_r <= v_above_nxt;
         i_above_r <= i_above_nxt;
         prim_r <= 1'b1;
      end
   end

endmodule

// *** trig_seq_checker.sv ***
// Concurrent checks on the trigger sequencer ports
`timescale 1ns/1ps
`include "trig_seq_defs.vh"
module trig_seq_checker (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // Register bus
   input wire [3:0] avs_address,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   // Sequencer and logging
   input wire meas_done_i,
   input wire source_o,
   input wire measure_o,
   input wire meter_done_o,
   input wire line1_trig_in_o,
   input wire log_en_o,
   input wire log_clear_o,
   input wire [15:0] log_keep_o
);
// ====
// Helpers
wire ctrl_wr = avs_write && avs_address == `REG_CTRL;
wire lvl_wr = avs_write && avs_address == `REG_LVL_CFG;
default clocking cb @(posedge core_clk_i);
endclocking
default disable iff (!rst_n_i);
sequence s_abort;
   avs_write && avs_address == `REG_CMD && avs_writedata[`CMD_ABORT];
endsequence
sequence s_quiet2;
   (!source_o && !measure_o) [*2];
endsequence
sequence s_meas_end;
   measure_o && meas_done_i;
endsequence
sequence s_mc_hold;
   meter_done_o [*8] ##1 meter_done_o [*2];
endsequence
// ====
// Properties
a_src_one: assert property (source_o |=> !source_o)
   else $error("source step longer than one cycle");
a_settle_gap: assert property (source_o |=> !measure_o)
   else $error("measure without settling step");
a_meas_ends: assert property (s_meas_end |=> !measure_o)
   else $error("measure held after done");
a_abort_halts: assert property (s_abort |=> s_quiet2)
   else $error("activity after abort");
a_line1_cause: assert property ($changed(line1_trig_in_o) |-> $past(ctrl_wr))
   else $error("line1 mode changed without control write");
a_keep_cause: assert property ($changed(log_keep_o) |-> $past(lvl_wr))
   else $error("offset changed without write");
a_log_cause: assert property ($rose(log_en_o) |-> $past(meas_done_i) || $past(meas_done_i, 2))
   else $error("logging started without a sample");
a_log_clear: assert property ($rose(log_en_o) |-> ##[0:1] log_clear_o)
   else $error("no buffer discard at logging start");
a_clear_pulse: assert property (log_clear_o |=> !log_clear_o)
   else $error("discard pulse too long");
a_log_hold: assert property ($fell(log_en_o) |-> $past(lvl_wr))
   else $error("logging stopped without write");
a_meter_pulse: assert property ($rose(meter_done_o) |-> s_mc_hold)
   else $error("meter pulse too short");
a_meter_cause: assert property ($rose(meter_done_o) |-> $past(measure_o && meas_done_i))
   else $error("meter pulse without a measurement");
endmodule
bind trig_seq trig_seq_checker chk (.core_clk_i, .rst_n_i, .avs_address, .avs_write, .avs_writedata,
   .meas_done_i, .source_o, .measure_o, .meter_done_o, .line1_trig_in_o, .log_en_o, .log_clear_o, .log_keep_o);

// *** meas_model.sv ***
// Behavioural measurement front end answering the sequencer
`timescale 1ns/1ps
module meas_model (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // Request and pacing
   input wire meas_req_i,
   input wire [1:0] lat_i,
   input wire [15:0] v_next_i,
   input wire [15:0] i_next_i,
   // Result
   output reg meas_done_o,
   output reg [15:0] v_o,
   output reg [15:0] i_o
);
reg [1:0] wait_r;
// ====
// Answer after lat_i cycles
always @(posedge core_clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      wait_r <= 2'h0;
      meas_done_o <= 1'b0;
      v_o <= 16'h0000;
      i_o <= 16'h0000;
   end else begin
      meas_done_o <= 1'b0;
      // Values mean nothing outside the done pulse
      v_o <= ~v_o;
      i_o <= ~i_o;
      wait_r <= 2'h0;
      if (meas_req_i && !meas_done_o) begin
         if (wait_r >= lat_i) begin
            meas_done_o <= 1'b1;
            v_o <= v_next_i;
            i_o <= i_next_i;
         end else begin
            wait_r <= wait_r + 2'h1;
         end
      end
   end
end
endmodule

// *** trig_seq_test.sv ***
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
`include "trig_seq_defs.vh"
module trig_seq_test;
// ====
// Signals
reg clk = 1'b0;
reg rst_n = 1'b0;
reg [3:0] avs_address = 4'h0;
reg avs_read = 1'b0;
reg avs_write = 1'b0;
reg [31:0] avs_writedata = 32'h0;
wire [31:0] avs_readdata;
wire avs_waitrequest;
reg trig_key = 1'b0;
reg ext_trig = 1'b0;
wire line1, meas_done, source, measure, meter_done, log_en, log_clear;
wire [15:0] v_meas, i_meas, log_keep;
reg [15:0] v_next = 16'h0;
reg [15:0] i_next = 16'h0;
reg [1:0] lat = 2'h0;
reg meas_d = 1'b0;
reg [31:0] exp_q[$];
integer seed = 45;
integer err_count = 0;
integer check_count = 0;
integer meas_cnt = 0;
integer mc_cnt = 0;
integer clr_cnt = 0;
always #50 clk = ~clk;
trig_seq #(.DELAY_UNIT(2)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .trig_key_i(trig_key), .ext_trig_i(ext_trig),
   .line1_trig_in_o(line1), .meas_done_i(meas_done), .v_meas_i(v_meas), .i_meas_i(i_meas),
   .source_o(source), .measure_o(measure), .meter_done_o(meter_done), .log_en_o(log_en),
   .log_clear_o(log_clear), .log_keep_o(log_keep));
meas_model MEAS (.core_clk_i(clk), .rst_n_i(rst_n), .meas_req_i(measure), .lat_i(lat),
   .v_next_i(v_next), .i_next_i(i_next), .meas_done_o(meas_done), .v_o(v_meas), .i_o(i_meas));
// ====
// Tasks
task chk(input [31:0] seen, input [31:0] want);
   begin
      check_count = check_count + 1;
      if (seen !== want) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   end
endtask
task end_sim;
   begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   end
endtask
task bus(input rd, input [3:0] a, input [31:0] d);
   integer n;
   begin
      @(posedge clk);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count = err_count + 1;
         end_sim;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   end
endtask
task wr(input [3:0] a, input [31:0] d);
   bus(1'b0, a, d);
endtask
task rd(input [3:0] a, input [31:0] e);
   begin
      exp_q.push_back(e);
      bus(1'b1, a, 32'h0);
   end
endtask
task wait_cnt(input integer n);
   integer k;
   begin
      k = 0;
      while (meas_cnt < n && k < 500) begin
         @(posedge clk);
         k = k + 1;
      end
      if (k >= 500) begin
         err_count = err_count + 1;
         end_sim;
      end
   end
endtask
task fire(input [3:0] kind);
   begin
      @(posedge clk);
      case (kind)
         4'h0: ext_trig <= 1'b1;
         4'h1: trig_key <= 1'b1;
         4'h2: wr(`REG_CMD, 32'h8);
         default: wr(`REG_CMD, 32'h4);
      endcase
      repeat (4) @(posedge clk);
      ext_trig <= 1'b0;
      trig_key <= 1'b0;
   end
endtask
task meas1(input [15:0] v, input [15:0] i);
   integer n;
   begin
      n = meas_cnt + 1;
      v_next <= v;
      i_next <= i;
      wr(`REG_CMD, 32'h1);
      wait_cnt(n);
      repeat (3) @(posedge clk);
   end
endtask
// ====
// Result monitor
always @(posedge clk) begin
   if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(avs_readdata, exp_q.pop_front());
   end
   meas_d <= measure && meas_done;
   if (measure && meas_done) begin
      meas_cnt <= meas_cnt + 1;
      lat <= 2'($random(seed));
   end
   if (meas_d && meter_done) mc_cnt <= mc_cnt + 1;
   if (log_clear) clr_cnt <= clr_cnt + 1;
end
initial begin
   repeat (60000) @(posedge clk);
   err_count = err_count + 1;
   end_sim;
end
// ====
// Scenarios
initial begin : main
   integer k;
   integer n0;
   reg [15:0] r;
   // Control words and their events, last entry first
   reg [55:0] ctl_t;
   reg [27:0] ev_t;
   ctl_t = 56'h02_04_26_04_08_10_08;
   ev_t = 28'h0123013;
   repeat (20) @(posedge clk);
   rst_n <= 1'b1;
   rd(`REG_CTRL, 32'h0);
   rd(`REG_ARM_CNT, 32'h1);
   rd(`REG_TRIG_CNT, 32'h1);
   rd(`REG_STATUS, 32'h0);
   rd(4'hF, 32'h0);
   wr(`REG_SAMP_CNT, 32'h9C5);
   rd(`REG_SAMP_CNT, 32'h1);
   wr(`REG_SAMP_CNT, 32'h9C4);
   rd(`REG_SAMP_CNT, 32'h9C4);
   wr(`REG_CTRL, 32'h6);
   rd(`REG_CTRL, 32'h0);
   wr(`REG_CTRL, 32'h18);
   rd(`REG_CTRL, 32'h0);
   // Nested counts: 2 arm x 3 trigger x 2 samples
   wr(`REG_ARM_CNT, 32'h2);
   wr(`REG_TRIG_CNT, 32'h3);
   wr(`REG_SAMP_CNT, 32'h2);
   wr(`REG_DELAY, 32'h1);
   wr(`REG_CTRL, 32'h80);
   wr(`REG_CMD, 32'h1);
   wait_cnt(12);
   repeat (30) @(posedge clk);
   chk(meas_cnt, 12);
   chk(mc_cnt, 12);
   rd(`REG_STATUS, 32'h0);
   rd(`REG_MEAS_DONE, 32'hC);
   wr(`REG_ARM_CNT, 32'h1);
   wr(`REG_TRIG_CNT, 32'h1);
   wr(`REG_SAMP_CNT, 32'h1);
   wr(`REG_DELAY, 32'h0);
   fire(4'h1);
   wait_cnt(13);
   for (k = 6; k >= 0; k = k - 1) begin
      wr(`REG_CTRL, {24'h0, ctl_t[8*k +: 8]});
      @(negedge clk);
      chk(line1, (ctl_t[8*k+1 +: 2] == 2'h1) || (ctl_t[8*k+3 +: 2] == 2'h1));
      n0 = meas_cnt;
      wr(`REG_CMD, 32'h1);
      repeat (20) @(posedge clk);
      chk(meas_cnt, n0);
      fire(ev_t[4*k +: 4]);
      wait_cnt(n0 + 1);
   end
   chk(mc_cnt, 13);
   // Local quick setup overrides trigger source and count
   wr(`REG_TRIG_CNT, 32'h3);
   wr(`REG_CTRL, 32'h68);
   wr(`REG_CTRL, 32'h48);
   n0 = meas_cnt;
   wr(`REG_CMD, 32'h1);
   wait_cnt(n0 + 1);
   repeat (30) @(posedge clk);
   chk(meas_cnt, n0 + 1);
   rd(`REG_CTRL, 32'h48);
   rd(`REG_TRIG_CNT, 32'h3);
   // Continuous run, then abort during a long settle
   wr(`REG_TRIG_CNT, 32'h1);
   wr(`REG_DELAY, 32'h14);
   wr(`REG_CTRL, 32'h1);
   n0 = meas_cnt;
   wait_cnt(n0 + 3);
   wr(`REG_CTRL, 32'h0);
   wr(`REG_CMD, 32'h2);
   @(negedge clk);
   n0 = meas_cnt;
   repeat (100) @(posedge clk);
   chk(meas_cnt, n0);
   rd(`REG_STATUS, 32'h0);
   // Voltage rising level trigger
   wr(`REG_DELAY, 32'h0);
   wr(`REG_VLVL, 32'h100);
   wr(`REG_LVL_CFG, 32'h0005_0003);
   @(negedge clk);
   chk(log_keep, 32'h5);
   r = 16'($random(seed));
   meas1(16'h00C0 + {10'h0, r[5:0]}, 16'h0);
   meas1(16'h00FF, 16'h0);
   chk(log_en, 32'h0);
   meas1(16'h0101 + {8'h0, r[15:8]}, 16'h0);
   chk(log_en, 32'h1);
   chk(clr_cnt, 32'h1);
   // Current falling level trigger, voltage disabled
   wr(`REG_ILVL, 32'h200);
   wr(`REG_LVL_CFG, 32'h0003_0004);
   @(negedge clk);
   chk(log_en, 32'h0);
   chk(log_keep, 32'h3);
   meas1(16'h0080, 16'h0201 + {10'h0, r[5:0]});
   meas1(16'h0180, 16'h0240);
   chk(log_en, 32'h0);
   meas1(16'h0080, 16'h01FF - {8'h0, r[15:8]});
   chk(log_en, 32'h1);
   chk(clr_cnt, 32'h2);
   repeat (4) @(posedge clk);
   end_sim;
end
endmodule
